// File: rtl/shared_external_bus_port.sv
// shared external bus port: master, slave, suspend and host grant logic
`timescale 1ns/10ps
module shared_external_bus_port (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        bus_clk,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic        req_cond,
  input  wire logic        req_cond_true,
  input  wire logic [1:0]  req_fmt,
  input  wire logic [31:0] req_addr,
  input  wire logic [39:0] req_wdata,
  input  wire logic [4:0]  bank_size_log2,
  input  wire logic [4:0]  page_size_log2,
  output logic             rsp_valid,
  output logic [39:0]      rsp_rdata,
  input  wire logic        bus_master,
  input  wire logic [31:0] ext_address_bus_i,
  output logic [31:0]      ext_address_bus_o,
  output logic             ext_address_bus_oe,
  input  wire logic [47:0] ext_data_bus_i,
  output logic [47:0]      ext_data_bus_o,
  output logic             ext_data_bus_oe,
  output logic [3:0]       bank_select_n_o,
  output logic             bank_select_oe,
  input  wire logic        rd_n_i,
  output logic             rd_n_o,
  output logic             rd_n_oe,
  input  wire logic        wr_n_i,
  output logic             wr_n_o,
  output logic             wr_n_oe,
  output logic             page_o,
  output logic             page_oe,
  output logic             bus_reference_clock_out_o,
  output logic             bus_reference_clock_out_oe,
  input  wire logic        sync_write_select_n_i,
  output logic             sync_write_select_n_o,
  output logic             sync_write_select_n_oe,
  input  wire logic        ack_i,
  output logic             ack_o,
  output logic             ack_oe,
  output logic             ack_keep_o,
  input  wire logic        suspend_bus_float_n,
  input  wire logic        host_bus_request_n,
  output logic             host_bus_grant_n_o,
  output logic             host_bus_grant_n_oe,
  input  wire logic        host_select_proc_a_n,
  input  wire logic        host_select_proc_b_n,
  output logic             host_hold_ready_n_o,
  output logic             host_hold_ready_n_oe
);
  // ----------------------------------------
  // core side request and answer handshake
  // ----------------------------------------
  logic        busy_r, req_tgl_r, rsp_s1_r, rsp_s2_r, rsp_seen_r, rsp_valid_r, rsp_tgl_r;
  logic [39:0] rsp_rdata_r, hold_wdata_r, mst_rdata_r;
  logic [31:0] hold_addr_r;
  logic [4:0]  hold_bs_r, hold_ps_r;
  logic [1:0]  hold_fmt_r;
  logic        hold_wr_r, hold_cond_r, hold_ctrue_r;
  assign req_ready = !busy_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_rdata = rsp_rdata_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp_s1_r <= 1'b0;
      rsp_s2_r <= 1'b0;
    end else begin
      rsp_s1_r <= rsp_tgl_r;
      rsp_s2_r <= rsp_s1_r;
    end
  end
  // request words stay frozen until the answer toggle returns
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_r       <= 1'b0;
      req_tgl_r    <= 1'b0;
      rsp_seen_r   <= 1'b0;
      rsp_valid_r  <= 1'b0;
      rsp_rdata_r  <= 40'h00_0000_0000;
      hold_addr_r  <= 32'h0000_0000;
      hold_wdata_r <= 40'h00_0000_0000;
      hold_bs_r    <= 5'h00;
      hold_ps_r    <= 5'h00;
      hold_fmt_r   <= 2'h0;
      hold_wr_r    <= 1'b0;
      hold_cond_r  <= 1'b0;
      hold_ctrue_r <= 1'b0;
    end else if (ce) begin
      rsp_valid_r <= 1'b0;
      if (req_valid && !busy_r) begin
        busy_r       <= 1'b1;
        req_tgl_r    <= !req_tgl_r;
        hold_addr_r  <= req_addr;
        hold_wdata_r <= req_wdata;
        hold_bs_r    <= bank_size_log2;
        hold_ps_r    <= page_size_log2;
        hold_fmt_r   <= req_fmt;
        hold_wr_r    <= req_write;
        hold_cond_r  <= req_cond;
        hold_ctrue_r <= req_cond_true;
      end else if (busy_r && rsp_s2_r != rsp_seen_r) begin
        rsp_seen_r  <= rsp_s2_r;
        busy_r      <= 1'b0;
        rsp_valid_r <= 1'b1;
        rsp_rdata_r <= mst_rdata_r;
      end
    end
  end
  // ----------------------------------------
  // bus clock domain: reset and pin synchronisers
  // ----------------------------------------
  logic        bres_s1, bres_n;
  logic [10:0] pin_s1, pin_s2;
  logic [31:0] addr_s1, addr_b;
  logic [47:0] data_s1, data_b;
  logic        ack_b, suspend_bus_float_n_b, hbr_b, rd_b, wr_b, sw_b, csa_b, csb_b, mst_b, ce_b, tgl_b;
  always_ff @(posedge bus_clk) begin
    bres_s1 <= resetn;
    bres_n  <= bres_s1;
  end
  always_ff @(posedge bus_clk) begin
    if (!bres_n) begin
      pin_s1  <= xbus_pkg::PIN_RST;
      pin_s2  <= xbus_pkg::PIN_RST;
      addr_s1 <= 32'h0000_0000;
      addr_b  <= 32'h0000_0000;
      data_s1 <= 48'h0000_0000_0000;
      data_b  <= 48'h0000_0000_0000;
    end else begin
      pin_s1  <= {ack_i, suspend_bus_float_n, host_bus_request_n, rd_n_i, wr_n_i,
                  sync_write_select_n_i, host_select_proc_a_n, host_select_proc_b_n,
                  bus_master, ce, req_tgl_r};
      pin_s2  <= pin_s1;
      addr_s1 <= ext_address_bus_i;
      addr_b  <= addr_s1;
      data_s1 <= ext_data_bus_i;
      data_b  <= data_s1;
    end
  end
  assign {ack_b, suspend_bus_float_n_b, hbr_b, rd_b, wr_b, sw_b, csa_b, csb_b, mst_b, ce_b, tgl_b} = pin_s2;
  // ----------------------------------------
  // lane placement and bank / page decode
  // ----------------------------------------
  function automatic logic [47:0] lane_put(input logic [1:0] f, input logic [39:0] w);
    lane_put = 48'h0000_0000_0000;
    case (f)
      xbus_pkg::FMT_W32: lane_put[47:16] = w[31:0]; // RULE_03
      xbus_pkg::FMT_W40: lane_put[47:8]  = w;       // RULE_04
      xbus_pkg::FMT_W16: lane_put[31:16] = w[15:0]; // RULE_05
      default:           lane_put[23:16] = w[7:0];  // RULE_06
    endcase
  endfunction : lane_put
  function automatic logic [39:0] lane_get(input logic [1:0] f, input logic [47:0] d);
    lane_get = 40'h00_0000_0000;
    case (f)
      xbus_pkg::FMT_W32: lane_get[31:0] = d[47:16]; // RULE_03
      xbus_pkg::FMT_W40: lane_get       = d[47:8];  // RULE_04
      xbus_pkg::FMT_W16: lane_get[15:0] = d[31:16]; // RULE_05
      default:           lane_get[7:0]  = d[23:16]; // RULE_06
    endcase
  endfunction : lane_get
  logic [31:0] ext_off, bank_idx, page_num, last_pg_r;
  logic [3:0]  bank_dec;
  logic        page_hit, pg_valid_r;
  always_comb begin
    ext_off  = hold_addr_r - xbus_pkg::EXT_BASE;
    bank_idx = ext_off >> hold_bs_r;
    page_num = hold_addr_r >> hold_ps_r;
    bank_dec = 4'hF;
    if (hold_addr_r >= xbus_pkg::EXT_BASE && bank_idx < 32'h0000_0004) begin
      bank_dec = ~(4'h1 << bank_idx[1:0]); // RULE_07
    end
    page_hit = !bank_dec[0] && (!pg_valid_r || page_num != last_pg_r); // RULE_12 RULE_13
  end
  // ----------------------------------------
  // master sequencer
  // ----------------------------------------
  xbus_pkg::mst_state_e mst_r;
  logic        tgl_seen_r, susp_r, cur_wr_r, cur_cond_r, cur_ctrue_r, cur_page_r;
  logic        refclk_r, ack_keep_r, flt, on_bus;
  logic [1:0]  cur_fmt_r, cnt_r;
  logic [31:0] cur_addr_r;
  logic [39:0] cur_wdata_r;
  logic [47:0] lanes_r;
  logic [3:0]  cur_bank_r;
  always_ff @(posedge bus_clk) begin
    if (!bres_n) begin
      susp_r <= 1'b0;
    end else if (ce_b) begin
      susp_r <= !suspend_bus_float_n_b; // RULE_20
    end
  end
  always_ff @(posedge bus_clk) begin
    if (!bres_n) begin
      mst_r       <= xbus_pkg::B_IDLE;
      tgl_seen_r  <= 1'b0;
      rsp_tgl_r   <= 1'b0;
      cnt_r       <= 2'h0;
      cur_addr_r  <= 32'h0000_0000;
      cur_wdata_r <= 40'h00_0000_0000;
      lanes_r     <= 48'h0000_0000_0000;
      cur_bank_r  <= 4'hF;
      cur_fmt_r   <= 2'h0;
      cur_wr_r    <= 1'b0;
      cur_cond_r  <= 1'b0;
      cur_ctrue_r <= 1'b0;
      cur_page_r  <= 1'b0;
      mst_rdata_r <= 40'h00_0000_0000;
    end else if (ce_b && !susp_r) begin // RULE_20
      case (mst_r)
        xbus_pkg::B_IDLE: begin
          if (mst_b && !hbr_b) begin
            mst_r <= xbus_pkg::B_REL; // RULE_21
          end else if (mst_b && tgl_b != tgl_seen_r) begin
            tgl_seen_r  <= tgl_b;
            cur_addr_r  <= hold_addr_r;
            cur_wdata_r <= hold_wdata_r;
            lanes_r     <= lane_put(hold_fmt_r, hold_wdata_r);
            cur_bank_r  <= bank_dec;
            cur_fmt_r   <= hold_fmt_r;
            cur_wr_r    <= hold_wr_r;
            cur_cond_r  <= hold_cond_r;
            cur_ctrue_r <= hold_ctrue_r;
            cur_page_r  <= page_hit;
            mst_r       <= xbus_pkg::B_ADDR;
          end
        end
        xbus_pkg::B_REL: mst_r <= xbus_pkg::B_GRANT;
        xbus_pkg::B_GRANT: begin
          if (hbr_b) begin
            mst_r <= xbus_pkg::B_IDLE; // RULE_22
          end
        end
        xbus_pkg::B_ADDR: begin
          cnt_r <= 2'h0;
          if (cur_cond_r && !cur_ctrue_r) begin
            mst_r <= xbus_pkg::B_DONE; // RULE_14
          end else begin
            mst_r <= xbus_pkg::B_STRB;
          end
        end
        xbus_pkg::B_STRB: begin
          if (cnt_r != xbus_pkg::STRB_LAST) begin
            cnt_r <= cnt_r + 2'h1;
          end else if (ack_b) begin // RULE_17
            mst_rdata_r <= lane_get(cur_fmt_r, data_b);
            mst_r       <= xbus_pkg::B_DONE;
          end
        end
        default: begin
          rsp_tgl_r <= !rsp_tgl_r;
          mst_r     <= xbus_pkg::B_IDLE;
        end
      endcase
    end
  end
  // remembers the open DRAM page of bank 0
  always_ff @(posedge bus_clk) begin
    if (!bres_n) begin
      last_pg_r  <= 32'h0000_0000;
      pg_valid_r <= 1'b0;
    end else if (ce_b && !susp_r && mst_r == xbus_pkg::B_IDLE && mst_b && hbr_b
                 && tgl_b != tgl_seen_r && !bank_dec[0]) begin
      last_pg_r  <= page_num; // RULE_12
      pg_valid_r <= 1'b1;
    end
  end
  always_ff @(posedge bus_clk) begin
    if (!bres_n) begin
      refclk_r   <= 1'b0;
      ack_keep_r <= 1'b1;
    end else if (ce_b) begin
      refclk_r   <= !refclk_r;
      ack_keep_r <= ack_b; // RULE_19
    end
  end
  assign flt    = susp_r || !mst_b || mst_r == xbus_pkg::B_REL || mst_r == xbus_pkg::B_GRANT;
  assign on_bus = mst_r == xbus_pkg::B_ADDR || mst_r == xbus_pkg::B_STRB;
  // ----------------------------------------
  // slave access to internal memory
  // ----------------------------------------
  xbus_pkg::slv_state_e slv_r;
  logic [47:0] imem [xbus_pkg::IMEM_DEPTH];
  logic [47:0] slv_rdata_r;
  logic [xbus_pkg::IMEM_AW-1:0] s_idx_r;
  logic        s_wr_r, s_async_r, slv_ok, host_async;
  assign slv_ok     = !mst_b || mst_r == xbus_pkg::B_GRANT;
  assign host_async = !hbr_b && (!csa_b || !csb_b);
  always_ff @(posedge bus_clk) begin
    if (!bres_n) begin
      slv_r       <= xbus_pkg::S_IDLE;
      s_idx_r     <= '0;
      s_wr_r      <= 1'b0;
      s_async_r   <= 1'b0;
      slv_rdata_r <= 48'h0000_0000_0000;
    end else if (ce_b) begin
      case (slv_r)
        xbus_pkg::S_IDLE: begin
          if (slv_ok && (!rd_b || !wr_b) && addr_b < xbus_pkg::EXT_BASE) begin // RULE_02 RULE_10
            s_idx_r   <= addr_b[xbus_pkg::IMEM_AW-1:0];
            s_async_r <= host_async;
            s_wr_r    <= host_async ? !wr_b : !sw_b; // RULE_15 RULE_16
            slv_r     <= xbus_pkg::S_WAIT;
          end
        end
        xbus_pkg::S_WAIT: begin
          slv_rdata_r <= imem[s_idx_r];
          slv_r       <= xbus_pkg::S_XFER;
        end
        default: begin
          if (rd_b && wr_b) begin
            slv_r <= xbus_pkg::S_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge bus_clk) begin
    if (ce_b && slv_r == xbus_pkg::S_WAIT && s_wr_r) begin
      imem[s_idx_r] <= data_b;
    end
  end
  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  assign ext_address_bus_o          = cur_addr_r;
  assign ext_address_bus_oe         = !flt; // RULE_01 RULE_02
  assign ext_data_bus_o             = (slv_r == xbus_pkg::S_XFER) ? slv_rdata_r : lanes_r;
  assign ext_data_bus_oe            = (!flt && on_bus && cur_wr_r)
                                      || (slv_r == xbus_pkg::S_XFER && !s_wr_r);
  assign bank_select_n_o            = on_bus ? cur_bank_r : 4'hF; // RULE_07 RULE_08
  assign bank_select_oe             = !flt; // RULE_11
  assign rd_n_o                     = !(mst_r == xbus_pkg::B_STRB && !cur_wr_r); // RULE_09
  assign wr_n_o                     = !(mst_r == xbus_pkg::B_STRB && cur_wr_r); // RULE_09
  assign rd_n_oe                    = !flt; // RULE_11
  assign wr_n_oe                    = !flt;
  assign page_o                     = on_bus && cur_page_r; // RULE_13
  assign page_oe                    = !flt;
  assign bus_reference_clock_out_o  = refclk_r;
  assign bus_reference_clock_out_oe = !flt; // RULE_11
  assign sync_write_select_n_o      = !(on_bus && cur_wr_r); // RULE_14
  assign sync_write_select_n_oe     = !flt;
  assign ack_o                      = slv_r != xbus_pkg::S_WAIT; // RULE_18
  assign ack_oe                     = slv_r != xbus_pkg::S_IDLE && !s_async_r;
  assign ack_keep_o                 = ack_keep_r; // RULE_19
  assign host_bus_grant_n_o         = mst_r != xbus_pkg::B_GRANT; // RULE_21 RULE_22
  assign host_bus_grant_n_oe        = mst_b;
  assign host_hold_ready_n_o        = !(slv_r == xbus_pkg::S_WAIT && s_async_r); // RULE_23
  assign host_hold_ready_n_oe       = host_async; // RULE_24
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_addr_drive: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_01
    mst_r == xbus_pkg::B_ADDR && !flt |-> ext_address_bus_oe && ext_address_bus_o == cur_addr_r)
    else $error("address not driven in address phase");
  a_lane_w32: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_03
    mst_r == xbus_pkg::B_STRB && cur_wr_r && cur_fmt_r == xbus_pkg::FMT_W32
    |-> ext_data_bus_o[47:16] == cur_wdata_r[31:0])
    else $error("32-bit word on wrong lanes");
  a_bank_idle: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_08
    mst_r == xbus_pkg::B_IDLE |-> bank_select_n_o == 4'hF)
    else $error("bank select active while idle");
  a_strobe_width: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_09
    $fell(rd_n_o) |-> !rd_n_o [*3])
    else $error("read strobe shorter than three cycles");
  a_page_bank0: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_13
    page_o |-> !bank_select_n_o[0])
    else $error("page outside bank 0");
  a_sw_leads_wr: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_14
    $fell(wr_n_o) |-> !$past(sync_write_select_n_o) && $past(mst_r) == xbus_pkg::B_ADDR)
    else $error("write strobe without early write select");
  a_cond_abort: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_14
    mst_r == xbus_pkg::B_ADDR && cur_cond_r && !cur_ctrue_r && ce_b && !susp_r
    |=> mst_r == xbus_pkg::B_DONE && rd_n_o && wr_n_o)
    else $error("false conditional access used a strobe");
  a_ack_holds: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_17
    mst_r == xbus_pkg::B_STRB && cnt_r == xbus_pkg::STRB_LAST && !ack_b
    |=> mst_r == xbus_pkg::B_STRB)
    else $error("access completed while acknowledge low");
  a_slave_wait: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_18
    slv_r == xbus_pkg::S_IDLE ##1 slv_r == xbus_pkg::S_WAIT && !s_async_r |-> ack_oe && !ack_o)
    else $error("slave wait state missing on acknowledge");
  a_float_suspend: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_20
    !suspend_bus_float_n_b && ce_b |=> !ext_address_bus_oe && !rd_n_oe && !bank_select_oe)
    else $error("bus not floated after suspend");
  a_grant_float: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_21
    !host_bus_grant_n_o && host_bus_grant_n_oe |-> !ext_address_bus_oe && !wr_n_oe && !page_oe)
    else $error("bus driven while granted to host");
  a_grant_hold: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_22
    !host_bus_grant_n_o && !hbr_b |=> !host_bus_grant_n_o)
    else $error("grant dropped before request released");
  a_ready_wait: assert property (@(posedge bus_clk) disable iff (!bres_n) // RULE_23
    slv_r == xbus_pkg::S_WAIT && s_async_r && host_hold_ready_n_oe |-> !host_hold_ready_n_o)
    else $error("host ready not low during wait");
endmodule : shared_external_bus_port

// File: rtl/xbus_pkg.sv
// shared external bus port: constants and types
// -------------------------------------------------------------------------
// Overview of operation
// RULE_01: as master the port drives the 32-bit address bus for external accesses.
// RULE_02: as slave the address bus is an input driven by the accessing party.
// RULE_03: 32-bit float and fixed data use data bits 47 to 16.
// RULE_04: 40-bit extended float data uses data bits 47 to 8.
// RULE_05: 16-bit short words use data bits 31 to 16.
// RULE_06: boot-from-PROM bytes use data bits 23 to 16 only.
// RULE_07: four active-low bank selects decoded from address, changing with the address.
// RULE_08: bank selects idle without access, active even for false conditional accesses.
// RULE_09: read or write strobe goes low for external and internal-processor accesses.
// RULE_10: outside parties assert read or write strobe to reach internal memory.
// RULE_11: only the bus master drives strobes, selects, page and reference clock.
// RULE_12: page signal marks a crossed DRAM page using the programmed page size.
// RULE_13: page signal only for bank 0 accesses, together with bank select 0.
// RULE_14: write select goes low with the address; without write strobe the write aborts.
// RULE_15: non-masters use write select to tell read from write.
// RULE_16: a host doing synchronous writes asserts write select.
// RULE_17: acknowledge low from outside holds off completion of an external access.
// RULE_18: as slave the port drives acknowledge low to add wait states.
// RULE_19: the master keeps its acknowledge input at the last driven level.
// RULE_20: suspend low floats the bus next cycle and halts pending accesses.
// RULE_21: host bus request makes the master float the bus, then grant.
// RULE_22: grant stays low until the request is released; host drives only then.
// RULE_23: host-ready goes low to add waits to asynchronous host accesses.
// RULE_24: host-ready is driven only while a chip select and bus request are low.
// -------------------------------------------------------------------------
package xbus_pkg;
  localparam logic [31:0] EXT_BASE   = 32'h0040_0000;
  localparam int          IMEM_AW    = 4;
  localparam int          IMEM_DEPTH = 16;
  localparam logic [1:0]  STRB_LAST  = 2'h2;
  localparam logic [1:0]  FMT_W32    = 2'h0;
  localparam logic [1:0]  FMT_W40    = 2'h1;
  localparam logic [1:0]  FMT_W16    = 2'h2;
  localparam logic [1:0]  FMT_B8     = 2'h3;
  localparam logic [10:0] PIN_RST    = 11'h7F8;
  typedef enum logic [2:0] {B_IDLE, B_REL, B_GRANT, B_ADDR, B_STRB, B_DONE} mst_state_e;
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_XFER} slv_state_e;
endpackage : xbus_pkg

// File: tb/ext_mem_model.sv
// external memory model answering the port's master accesses
`timescale 1ns/10ps
module ext_mem_model (
  input  wire logic        bus_clk,
  input  wire logic [31:0] addr,
  input  wire logic [47:0] wdata,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [3:0]  waits,
  output logic [47:0]      rdata,
  output logic             rdata_en,
  output logic             ack,
  output logic             ack_en
);
  logic [47:0] mem [16];
  logic [3:0]  cnt_r;
  // ----------------------------------------
  // wait-state counter and storage
  // ----------------------------------------
  always @(posedge bus_clk) begin
    cnt_r <= (rd_n && wr_n) ? 4'h0 : ((cnt_r == 4'hF) ? cnt_r : cnt_r + 4'h1);
    if (!wr_n && ack)
      mem[addr[3:0]] <= wdata;
  end
  assign ack_en   = !(rd_n && wr_n);
  assign ack      = (cnt_r >= waits);
  assign rdata_en = !rd_n;
  assign rdata    = mem[addr[3:0]];
endmodule : ext_mem_model

// File: tb/shared_external_bus_port_tb.sv
// self-checking bench of the shared external bus port
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module shared_external_bus_port_tb;
  logic clk = 1'h0, bus_clk = 1'h0, resetn = 1'h0, ce = 1'h1, req_valid = 1'h0;
  logic req_write = 1'h0, req_cond = 1'h0, req_cond_true = 1'h0, bus_master = 1'h1;
  logic suspend_bus_float_n = 1'h1, host_bus_request_n = 1'h1, host_select_proc_a_n = 1'h1;
  logic host_select_proc_b_n = 1'h1, host_rd_n = 1'h1, host_wr_n = 1'h1, host_sw_n = 1'h1;
  logic [1:0]  req_fmt = 2'h0;
  logic [31:0] req_addr = 32'h0, host_addr = 32'h0, ext_address_bus_i, ext_address_bus_o, waddr;
  logic [39:0] req_wdata = 40'h0, rsp_rdata, got;
  logic [4:0]  bank_size_log2 = 5'h10, page_size_log2 = 5'h08;
  logic [47:0] ext_data_bus_i, ext_data_bus_o, mem_rdata, wlane, last_data = 48'h0;
  logic [47:0] host_data = 48'hC3C3_5A5A_0F0F;
  logic [3:0]  bank_select_n_o, waits = 4'h0, bs_seen;
  logic host_drv = 1'h0, req_ready, rsp_valid, ext_address_bus_oe, ext_data_bus_oe;
  logic bank_select_oe, rd_n_i, rd_n_o, rd_n_oe, wr_n_i, wr_n_o, wr_n_oe, page_o, page_oe;
  logic bus_reference_clock_out_o, bus_reference_clock_out_oe, sync_write_select_n_i;
  logic sync_write_select_n_o, sync_write_select_n_oe, ack_i, ack_o, ack_oe, ack_keep_o;
  logic host_bus_grant_n_o, host_bus_grant_n_oe, host_hold_ready_n_o, host_hold_ready_n_oe;
  logic mem_rdata_en, mem_ack, mem_ack_en, wr_seen, rd_seen, pg_seen, sw_seen, aw_seen, hr_seen;
  int   fails = 0, total_checks = 0, rd_len = 0, cycles = 0;
  // ----------------------------------------
  // clocks, wires and far side
  // ----------------------------------------
  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #32 bus_clk = ~bus_clk;
  end
  assign ext_address_bus_i = ext_address_bus_oe ? ext_address_bus_o : host_addr;
  assign rd_n_i = rd_n_oe ? rd_n_o : host_rd_n;
  assign wr_n_i = wr_n_oe ? wr_n_o : host_wr_n;
  assign sync_write_select_n_i = sync_write_select_n_oe ? sync_write_select_n_o : host_sw_n;
  assign ack_i = ack_oe ? ack_o : (mem_ack_en ? mem_ack : ack_keep_o);
  assign ext_data_bus_i = ext_data_bus_oe ? ext_data_bus_o : mem_rdata_en ? mem_rdata :
                          host_drv ? host_data : ~last_data;
  always @(posedge bus_clk) last_data <= ext_data_bus_i;
  shared_external_bus_port dut_u (.*);
  ext_mem_model mem_u (.bus_clk(bus_clk), .addr(ext_address_bus_i), .wdata(ext_data_bus_i),
    .rd_n(rd_n_oe ? rd_n_o : 1'h1), .wr_n(wr_n_oe ? wr_n_o : 1'h1), .waits(waits),
    .rdata(mem_rdata), .rdata_en(mem_rdata_en), .ack(mem_ack), .ack_en(mem_ack_en));
  always @(negedge bus_clk) begin
    if (!wr_n_o && wr_n_oe) {wr_seen, wlane, waddr} <= {1'h1, ext_data_bus_o, ext_address_bus_o};
    if (!rd_n_o && rd_n_oe) {rd_seen, rd_len} <= {1'h1, rd_len + 1};
    if (bank_select_oe && bank_select_n_o != 4'hF) bs_seen <= bank_select_n_o;
    if (page_oe && page_o) pg_seen <= 1'h1;
    if (sync_write_select_n_oe && !sync_write_select_n_o) sw_seen <= 1'h1;
    if (ack_oe && !ack_o) aw_seen <= 1'h1;
    if (host_hold_ready_n_oe && !host_hold_ready_n_o) hr_seen <= 1'h1;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      summarize();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [47:0] lane(input logic [1:0] f, input logic [39:0] v);
    case (f)
      xbus_pkg::FMT_W32: lane = {v[31:0], 16'h0000};
      xbus_pkg::FMT_W40: lane = {v, 8'h00};
      xbus_pkg::FMT_W16: lane = {16'h0000, v[15:0], 16'h0000};
      default:           lane = {24'h000000, v[7:0], 16'h0000};
    endcase
  endfunction : lane
  task automatic bw(input int n);
    repeat (n) @(posedge bus_clk);
    @(posedge clk);
  endtask : bw
  task automatic issue(input logic w, c, t, input logic [1:0] f, input logic [31:0] a);
    {wr_seen, rd_seen, pg_seen, sw_seen, aw_seen, hr_seen} = 6'h00;
    bs_seen = 4'hF;
    rd_len = 0;
    @(posedge clk);
    req_valid <= 1'h1;
    req_write <= w;
    req_cond <= c;
    req_cond_true <= t;
    req_fmt <= f;
    req_addr <= a;
    req_wdata <= 40'hA5_1234_5678 ^ {38'h0, f};
    @(posedge clk);
    req_valid <= 1'h0;
  endtask : issue
  task automatic finish;
    for (int n = 0; n < 2000 && rsp_valid !== 1'h1; n++) @(negedge clk);
    `CHK("response", 2'h3, {rsp_valid, req_ready})
    got = rsp_rdata;
    @(posedge clk);
  endtask : finish
  task automatic op(input logic w, c, t, input logic [1:0] f, input logic [31:0] a);
    issue(w, c, t, f, a);
    finish();
  endtask : op
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_lanes;
    for (int f = 0; f < 4; f++) begin
      op(1'h1, 1'h0, 1'h0, f[1:0], xbus_pkg::EXT_BASE + f);
      `CHK("lanes", lane(f[1:0], req_wdata), wlane & lane(f[1:0], 40'hFF_FFFF_FFFF))
      `CHK("address", xbus_pkg::EXT_BASE + f, waddr)
      `CHK("bank", 4'hE, bs_seen)
      `CHK("page", f == 0, pg_seen)
      op(1'h0, 1'h0, 1'h0, f[1:0], xbus_pkg::EXT_BASE + f);
      `CHK("read", lane(f[1:0], req_wdata), lane(f[1:0], got))
      `CHK("rd strobe", 1'h1, rd_seen)
    end
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_banks;
    op(1'h1, 1'h0, 1'h0, 2'h0, xbus_pkg::EXT_BASE + 32'h0001_0000);
    `CHK("bank1", 4'hD, bs_seen)
    `CHK("page bank1", 1'h0, pg_seen)
    op(1'h1, 1'h0, 1'h0, 2'h0, xbus_pkg::EXT_BASE + 32'h0000_0100);
    `CHK("page cross", 1'h1, pg_seen)
    op(1'h1, 1'h1, 1'h0, 2'h0, xbus_pkg::EXT_BASE + 32'h2);
    `CHK("cond wr", 1'h0, wr_seen)
    `CHK("cond sw", 1'h1, sw_seen)
    `CHK("cond bank", 4'hE, bs_seen)
    op(1'h0, 1'h0, 1'h0, 2'h2, xbus_pkg::EXT_BASE + 32'h2);
    `CHK("kept", 40'h5678 ^ 40'h2, {24'h0, got[15:0]})
    $display("test banks done");
  endtask : t_banks
  task automatic t_wait;
    waits = 4'h6;
    op(1'h0, 1'h0, 1'h0, 2'h0, xbus_pkg::EXT_BASE);
    `CHK("wait len", 1'h1, rd_len >= 9)
    waits = 4'h0;
    suspend_bus_float_n <= 1'h0;
    bw(4);
    issue(1'h0, 1'h0, 1'h0, 2'h0, xbus_pkg::EXT_BASE);
    bw(16);
    `CHK("susp rd", 1'h0, rd_seen)
    `CHK("susp oe", 1'h0, ext_address_bus_oe)
    suspend_bus_float_n <= 1'h1;
    finish();
    `CHK("resumed", 1'h1, rd_seen)
    $display("test wait done");
  endtask : t_wait
  task automatic t_grant;
    host_bus_request_n <= 1'h0;
    for (int n = 0; n < 40 && host_bus_grant_n_o !== 1'h0; n++) bw(1);
    `CHK("grant", 2'h1, {host_bus_grant_n_o, host_bus_grant_n_oe})
    `CHK("floated", 3'h0, {ext_address_bus_oe, rd_n_oe, bank_select_oe})
    `CHK("refclk oe", 1'h0, bus_reference_clock_out_oe)
    bw(10);
    `CHK("grant held", 1'h0, host_bus_grant_n_o)
    host_bus_request_n <= 1'h1;
    for (int n = 0; n < 40 && host_bus_grant_n_o !== 1'h1; n++) bw(1);
    `CHK("ungrant", 1'h1, host_bus_grant_n_o)
    $display("test grant done");
  endtask : t_grant
  task automatic t_slave;
    bus_master <= 1'h0;
    bw(4);
    {aw_seen, hr_seen} = 2'h0;
    host_addr <= 32'h3;
    host_drv <= 1'h1;
    host_sw_n <= 1'h0;
    host_wr_n <= 1'h0;
    bw(8);
    {host_drv, host_sw_n, host_wr_n} <= 3'h7;
    bw(2);
    `CHK("slave ack", 1'h1, aw_seen)
    host_rd_n <= 1'h0;
    bw(8);
    `CHK("slave data", {1'h1, host_data}, {ext_data_bus_oe, ext_data_bus_o})
    `CHK("slave rd oe", 1'h0, rd_n_oe)
    `CHK("no ready", 1'h0, hr_seen)
    host_rd_n <= 1'h1;
    bw(2);
    {host_bus_request_n, host_select_proc_a_n, host_rd_n} <= 3'h0;
    bw(8);
    `CHK("host ready", 1'h1, hr_seen)
    {host_bus_request_n, host_select_proc_a_n, host_rd_n, bus_master} <= 4'hF;
    bw(4);
    $display("test slave done");
  endtask : t_slave
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'h1;
    t_lanes();
    t_banks();
    t_wait();
    t_grant();
    t_slave();
    summarize();
  end
endmodule : shared_external_bus_port_tb
